// >>> pkg/tdm_port_defines.svh
`ifndef TDM_PORT_DEFINES_SVH
`define TDM_PORT_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_CTRL     5'h00
`define OFS_TX_SLOT  5'h04
`define OFS_RX_SLOT  5'h08
`define OFS_TX_DATA  5'h0c
`define OFS_RX_DATA  5'h10
`define OFS_STATUS   5'h14

// Control register field positions
`define CTRL_HWY_EN    0
`define CTRL_FS_POL    1
`define CTRL_OUT_SEL   2
`define CTRL_RX_SEL    3
`define CTRL_A_EN      4
`define CTRL_B_EN      5
`define CTRL_TX_EDGE   6
`define CTRL_RX_EDGE   7
`define CTRL_TX_INV    8
`define CTRL_TX_ORDER  9
`define CTRL_RX_INV    10
`define CTRL_RX_ORDER  11
`define CTRL_RX_INSEL  12
`define CTRL_W         13

// Slot register layout: slot number low, bit offset above it
`define SLOT_W         11
`define POS_W          12

// Reset values
`define CTRL_RESET     13'h0000
`define SLOT_RESET     11'h000
`define BYTE_RESET     8'h00

// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// >>> pkg/tdm_port_pkg.sv
package tdm_port_pkg;
`include "tdm_port_defines.svh"

   // Slot timer: waiting for first frame, or counting bits
   typedef enum logic [1:0] {TS_IDLE = 2'h1, TS_RUN = 2'h2} slot_state_type;

   // Synchroniser chain plus edge history
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } sync_state_type;

   // Bit position counter of one direction
   typedef struct packed {
      slot_state_type     st;
      logic [`POS_W-1:0]  pos;
      logic               armed;
      logic               fprev;
      logic               win;
      logic [2:0]         idx;
      logic               step;
   } slot_state_pack_type;

   // Whole state of the port
   typedef struct packed {
      logic [`CTRL_W-1:0] ctrl;
      logic [`SLOT_W-1:0] tx_slot;
      logic [`SLOT_W-1:0] rx_slot;
      logic [7:0]         tx_data;
      logic [7:0]         rx_data;
      logic [7:0]         rx_shift;
      logic               rx_full;
      logic               aw_got;
      logic [4:0]         aw_addr;
      logic               w_got;
      logic [`CTRL_W-1:0] wdata;
      logic [1:0]         wstrb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [`CTRL_W-1:0] rdata;
      logic [1:0]         rresp;
      logic               a_out;
      logic               a_oe_n;
      logic               b_out;
      logic               b_oe_n;
   } port_state_type;
endpackage

// >>> verilog/edge_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser with edge pulses taken after the second flop
module edge_sync
   import tdm_port_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   sync_state_type r_reg;   // Chain state
   sync_state_type r_next;  // Next chain state

   // Shift the pin through; s1 feeds only s2
   always_comb
   begin
      r_next    = r_reg;
      r_next.s1 = pin;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
   end

   // Register the chain
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         r_reg <= '0;
      else if (ce)
         r_reg <= r_next;
   end

   // Edges compare second and third stage only
   assign level = r_reg.s2;
   assign rise  = r_reg.s2 & ~r_reg.s3;
   assign fall  = ~r_reg.s2 & r_reg.s3;
endmodule

// >>> verilog/slot_timer.sv
`timescale 1ns/1ps
// Counts bit clock edges from frame start and flags the 8-bit slot
module slot_timer
   import tdm_port_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               enable,
   input  wire logic               frame,
   input  wire logic               tick,
   input  wire logic [`SLOT_W-1:0] slot_cfg,
   output logic                    win,
   output logic [2:0]              idx,
   output logic                    step
);
   slot_state_pack_type r_reg;   // Timer state
   slot_state_pack_type r_next;  // Next timer state
   logic [`POS_W-1:0]   start;   // First bit position of the slot
   logic [`POS_W-1:0]   diff;    // Distance from slot start
   logic                rise;    // Frame sync just became active

   // Slot start is slot number times eight plus bit offset
   assign start = {1'b0, slot_cfg[7:0], 3'h0}
                + {9'h000, slot_cfg[10:8]};
   assign rise  = frame & ~r_reg.fprev;

   // Arm on frame start, restart count on next bit edge
   always_comb
   begin
      r_next       = r_reg;
      r_next.fprev = frame;
      r_next.step  = tick;
      if (tick)
      begin
         if (r_reg.armed || rise)
         begin
            r_next.pos   = '0;
            r_next.st    = TS_RUN;
            r_next.armed = 1'b0;
         end
         // Saturate so a lost frame sync never wraps into a slot
         else if (r_reg.st == TS_RUN && r_reg.pos != {`POS_W{1'b1}})
            r_next.pos = r_reg.pos + `POS_W'(1);
      end
      else if (rise)
         r_next.armed = 1'b1;
      // Frame sync ignored while the highway is off
      if (!enable)
      begin
         r_next.st    = TS_IDLE;
         r_next.armed = 1'b0;
      end
      diff       = r_next.pos - start;
      r_next.win = (r_next.st == TS_RUN) && (r_next.pos >= start)
                 && (diff < `POS_W'(8));
      r_next.idx = diff[2:0];
   end

   // Register timer state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         r_reg <= '{st: TS_IDLE, default: '0};
      else if (ce)
         r_reg <= r_next;
   end

   assign win  = r_reg.win;
   assign idx  = r_reg.idx;
   assign step = r_reg.step;

   chk_pos_advance: assert property (@(posedge clk) disable iff (!rst_n)
      ce && tick && enable && r_reg.st == TS_RUN && !r_reg.armed && !rise
      && r_reg.pos != {`POS_W{1'b1}}
      |=> r_reg.pos == $past(r_reg.pos) + `POS_W'(1))
      else $error("bit position did not advance on bit edge");
endmodule

// >>> verilog/tdm_serial_port.sv
`timescale 1ns/1ps
module tdm_serial_port
   import tdm_port_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        tx_bit_clock,
   input  wire logic        frame_sync_in,
   input  wire logic        rx_data_in_a,
   input  wire logic        rx_clk_or_data_b,
   output logic             tx_data_out_a,
   output logic             tx_data_out_a_oe_n,
   output logic             tx_b_strobe_pin,
   output logic             tx_b_strobe_pin_oe_n
);
   port_state_type     r_reg;       // All port state
   port_state_type     r_next;      // Next port state
   logic               txc_lvl;     // Transmit clock, synchronised
   logic               txc_rise;    // Transmit clock rising edge
   logic               txc_fall;    // Transmit clock falling edge
   logic               p21_lvl;     // Shared receive pin level
   logic               p21_rise;    // Shared receive pin rising edge
   logic               p21_fall;    // Shared receive pin falling edge
   logic               fs_lvl;      // Frame sync level
   logic               rxa_lvl;     // Receive input A level
   logic               frame;       // Frame sync active, polarity applied
   logic               tx_tick;     // Transmit launch edge
   logic               rx_tick;     // Receive sampling edge
   logic               rx_din;      // Selected receive bit
   logic               tx_win;      // Transmit slot open
   logic [2:0]         tx_idx;      // Bit number within transmit slot
   logic               tx_step;     // Transmit edge just taken
   logic               rx_win;      // Receive slot open
   logic [2:0]         rx_idx;      // Bit number within receive slot
   logic               rx_step;     // Receive edge just taken
   logic [`CTRL_W-1:0] wmask;       // Byte-lane mask of the write
   logic [2:0]         bpos;        // Byte bit chosen by order
   logic [7:0]         rx_byte;     // Receive byte with new bit merged
   logic               a_valid;     // A carries a valid bit this cycle

   // Every highway pin passes a two-flop chain first
   edge_sync u_txc (.clk(clk), .rst_n(rst_n), .ce(ce),
      .pin(tx_bit_clock), .level(txc_lvl),
      .rise(txc_rise), .fall(txc_fall));
   edge_sync u_p21 (.clk(clk), .rst_n(rst_n), .ce(ce),
      .pin(rx_clk_or_data_b), .level(p21_lvl),
      .rise(p21_rise), .fall(p21_fall));
   edge_sync u_fs (.clk(clk), .rst_n(rst_n), .ce(ce),
      .pin(frame_sync_in), .level(fs_lvl),
      .rise(), .fall());
   edge_sync u_rxa (.clk(clk), .rst_n(rst_n), .ce(ce),
      .pin(rx_data_in_a), .level(rxa_lvl),
      .rise(), .fall());

   // Frame sync polarity: 1 means active high
   assign frame = (fs_lvl == r_reg.ctrl[`CTRL_FS_POL]);

   // Falling edge after reset, rising edge when inverted
   assign tx_tick = r_reg.ctrl[`CTRL_TX_EDGE] ? txc_rise
                                              : txc_fall;

   // Receive clock comes from the shared pin or the transmit clock
   always_comb
   begin
      if (r_reg.ctrl[`CTRL_RX_SEL])
         rx_tick = r_reg.ctrl[`CTRL_RX_EDGE] ? txc_fall : txc_rise;
      else
         rx_tick = r_reg.ctrl[`CTRL_RX_EDGE] ? p21_fall
                                             : p21_rise;
      // Input B exists only while the shared pin carries data
      if (r_reg.ctrl[`CTRL_RX_SEL] && r_reg.ctrl[`CTRL_RX_INSEL])
         rx_din = p21_lvl;
      else
         rx_din = rxa_lvl;
   end

   // Independent slot timers so the two directions may differ in rate
   slot_timer u_tx_slot (.clk(clk), .rst_n(rst_n), .ce(ce),
      .enable(r_reg.ctrl[`CTRL_HWY_EN]), .frame(frame),
      .tick(tx_tick), .slot_cfg(r_reg.tx_slot),
      .win(tx_win), .idx(tx_idx), .step(tx_step));
   slot_timer u_rx_slot (.clk(clk), .rst_n(rst_n), .ce(ce),
      .enable(r_reg.ctrl[`CTRL_HWY_EN]), .frame(frame),
      .tick(rx_tick), .slot_cfg(r_reg.rx_slot),
      .win(rx_win), .idx(rx_idx), .step(rx_step));

   // Write lanes: byte 0 for bits 7:0, byte 1 for the rest
   assign wmask = {{(`CTRL_W-8){r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};

   // Slave handshakes: one write and one read in flight at most
   assign s_axi_awready = ~r_reg.aw_got & ~r_reg.bvalid;
   assign s_axi_wready  = ~r_reg.w_got & ~r_reg.bvalid;
   assign s_axi_arready = ~r_reg.rvalid;
   assign s_axi_bvalid  = r_reg.bvalid;
   assign s_axi_bresp   = r_reg.bresp;
   assign s_axi_rvalid  = r_reg.rvalid;
   assign s_axi_rresp   = r_reg.rresp;
   assign s_axi_rdata   = {{(32-`CTRL_W){1'b0}}, r_reg.rdata};

   // Strobe marks bits that A really carries
   assign a_valid = tx_win & r_reg.ctrl[`CTRL_A_EN];

   // Bus, receive shifter and pin drivers
   always_comb
   begin
      r_next  = r_reg;
      bpos    = 3'h0;
      rx_byte = r_reg.rx_shift;

      // Address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         r_next.aw_got  = 1'b1;
         r_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         r_next.w_got = 1'b1;
         r_next.wdata = s_axi_wdata[`CTRL_W-1:0];
         r_next.wstrb = s_axi_wstrb[1:0];
      end

      // Both halves present: perform the write
      if (r_reg.aw_got && r_reg.w_got)
      begin
         r_next.aw_got = 1'b0;
         r_next.w_got  = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp  = `RESP_OKAY;
         case ({r_reg.aw_addr[4:2], 2'h0})
            `OFS_CTRL:
               r_next.ctrl = (r_reg.ctrl & ~wmask) | (r_reg.wdata & wmask);
            `OFS_TX_SLOT:
               r_next.tx_slot = (r_reg.tx_slot & ~wmask[`SLOT_W-1:0])
                              | (r_reg.wdata[`SLOT_W-1:0]
                                 & wmask[`SLOT_W-1:0]);
            `OFS_RX_SLOT:
               r_next.rx_slot = (r_reg.rx_slot & ~wmask[`SLOT_W-1:0])
                              | (r_reg.wdata[`SLOT_W-1:0]
                                 & wmask[`SLOT_W-1:0]);
            `OFS_TX_DATA:
               if (r_reg.wstrb[0])
                  r_next.tx_data = r_reg.wdata[7:0];
            // Read-only registers ignore writes
            `OFS_RX_DATA, `OFS_STATUS:
               r_next.bresp = `RESP_OKAY;
            default:
               r_next.bresp = `RESP_SLVERR;
         endcase
      end
      if (r_reg.bvalid && s_axi_bready)
         r_next.bvalid = 1'b0;

      // Read: answer one cycle after the address is taken
      if (r_reg.rvalid && s_axi_rready)
         r_next.rvalid = 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
         r_next.rvalid = 1'b1;
         r_next.rresp  = `RESP_OKAY;
         r_next.rdata  = '0;
         case ({s_axi_araddr[4:2], 2'h0})
            `OFS_CTRL:    r_next.rdata = r_reg.ctrl;
            `OFS_TX_SLOT: r_next.rdata[`SLOT_W-1:0] = r_reg.tx_slot;
            `OFS_RX_SLOT: r_next.rdata[`SLOT_W-1:0] = r_reg.rx_slot;
            `OFS_TX_DATA: r_next.rdata[7:0] = r_reg.tx_data;
            `OFS_RX_DATA:
            begin
               r_next.rdata[7:0] = r_reg.rx_data;
               r_next.rx_full    = 1'b0;
            end
            `OFS_STATUS:
               r_next.rdata[2:0] = {rx_win, tx_win, r_reg.rx_full};
            default:      r_next.rresp = `RESP_SLVERR;
         endcase
      end

      // Receive: capture only inside the slot; a new byte wins
      // over a read that clears the full flag in the same cycle
      if (rx_step && rx_win)
      begin
         bpos = r_reg.ctrl[`CTRL_RX_ORDER] ? (3'h7 - rx_idx) : rx_idx;
         rx_byte[bpos] = rx_din ^ r_reg.ctrl[`CTRL_RX_INV];
         r_next.rx_shift = rx_byte;
         if (rx_idx == 3'h7)
         begin
            r_next.rx_data = rx_byte;
            r_next.rx_full = 1'b1;
         end
      end

      // Transmit bit: order then invert; B carries the same bit unless the strobe is selected
      bpos = r_reg.ctrl[`CTRL_TX_ORDER] ? (3'h7 - tx_idx) : tx_idx;
      r_next.a_out = r_reg.tx_data[bpos]
                   ^ r_reg.ctrl[`CTRL_TX_INV];
      // A drives only in its slot, else floats
      r_next.a_oe_n = ~a_valid;
      if (r_reg.ctrl[`CTRL_OUT_SEL])
      begin
         // Strobe always driven; enable B is overridden
         r_next.b_out  = ~a_valid;
         r_next.b_oe_n = 1'b0;
      end
      else
      begin
         r_next.b_out  = r_next.a_out;
         r_next.b_oe_n = ~(tx_win & r_reg.ctrl[`CTRL_B_EN]);
      end
   end

   // Register all state; pins float and control clears in reset
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         r_reg <= '{ctrl: `CTRL_RESET, tx_slot: `SLOT_RESET,
                    rx_slot: `SLOT_RESET, a_out: 1'b1, a_oe_n: 1'b1,
                    b_out: 1'b1, b_oe_n: 1'b1, default: '0};
      else if (ce)
         r_reg <= r_next;
   end

   assign tx_data_out_a        = r_reg.a_out;
   assign tx_data_out_a_oe_n   = r_reg.a_oe_n;
   assign tx_b_strobe_pin      = r_reg.b_out;
   assign tx_b_strobe_pin_oe_n = r_reg.b_oe_n;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   chk_strobe_pin_driven: assert property (
      ce && r_reg.ctrl[`CTRL_OUT_SEL] |=> !tx_b_strobe_pin_oe_n)
      else $error("strobe pin not driven in strobe mode");
   chk_strobe_low_slot: assert property (
      ce && r_reg.ctrl[`CTRL_OUT_SEL]
      && $past(ce) && $past(r_reg.ctrl[`CTRL_OUT_SEL])
      |-> tx_b_strobe_pin == tx_data_out_a_oe_n)
      else $error("strobe does not match valid bits on A");
   chk_b_override: assert property (
      ce && r_reg.ctrl[`CTRL_OUT_SEL]
      && r_reg.ctrl[`CTRL_B_EN] && tx_win && !r_reg.ctrl[`CTRL_A_EN]
      |=> tx_b_strobe_pin)
      else $error("data appeared on strobe pin");
   chk_b_drives: assert property (
      ce && !r_reg.ctrl[`CTRL_OUT_SEL]
      && r_reg.ctrl[`CTRL_B_EN] && tx_win |=> !tx_b_strobe_pin_oe_n)
      else $error("output B idle in its slot");
   chk_a_drives: assert property (
      ce && r_reg.ctrl[`CTRL_A_EN] && tx_win |=> !tx_data_out_a_oe_n)
      else $error("output A idle in its slot");
   chk_same_data: assert property (
      !tx_data_out_a_oe_n
      && !tx_b_strobe_pin_oe_n && !$past(r_reg.ctrl[`CTRL_OUT_SEL])
      |-> tx_data_out_a == tx_b_strobe_pin)
      else $error("outputs A and B differ");
   chk_hiz_outside: assert property (
      ce && !tx_win |=> tx_data_out_a_oe_n)
      else $error("output A driven outside slot");
   chk_hwy_off_idle: assert property (
      ce && !r_reg.ctrl[`CTRL_HWY_EN] |=> !tx_win && !rx_win)
      else $error("slot opened with highway disabled");
   chk_rx_byte_slot: assert property (
      $rose(r_reg.rx_full)
      |-> $past(rx_step && rx_win && rx_idx == 3'h7))
      else $error("receive byte completed outside slot");

   cov_strobe_mode: cover property (r_reg.ctrl[`CTRL_OUT_SEL]
      && !tx_b_strobe_pin);
   cov_dual_output: cover property (!tx_data_out_a_oe_n
      && !tx_b_strobe_pin_oe_n && !r_reg.ctrl[`CTRL_OUT_SEL]);
   cov_rx_shared_clock: cover property ($rose(r_reg.rx_full)
      && r_reg.ctrl[`CTRL_RX_SEL]);
endmodule

// >>> bench/tdm_highway_model.sv
`timescale 1ns/1ps
// Far side of the link: a highway that clocks one short frame on request
module tdm_highway_model (
   input  wire logic       go,
   input  wire logic [7:0] rx_byte,
   output logic            bit_clock,
   output logic            frame_sync,
   output logic            rx_a,
   output logic            rx_b,
   output logic            busy
);
   // Idle: clock stands low between frames
   initial
   begin
      bit_clock = 1'b0;
      frame_sync = 1'b0;
      rx_a = 1'b0;
      rx_b = 1'b1;
      busy = 1'b0;
   end

   // One frame, 64 ns bits; offset keeps pin edges off the master edge
   always @(posedge go)
   begin
      busy = 1'b1;
      #3;
      // Active-high sync one bit long, LSB present before the first rise
      frame_sync = 1'b1;
      rx_a = rx_byte[0];
      rx_b = ~rx_byte[0];
      #32 bit_clock = 1'b1;
      for (int k = 1; k < 11; k++)
      begin
         #32 bit_clock = 1'b0;
         frame_sync = 1'b0;
         // Past the byte the lines flip each bit, so stale data shows
         rx_a = (k < 8) ? rx_byte[k] : ~rx_a;
         rx_b = (k < 8) ? ~rx_byte[k] : ~rx_b;
         #32 bit_clock = 1'b1;
      end
      #32 bit_clock = 1'b0;
      busy = 1'b0;
   end
endmodule

// >>> bench/tdm_serial_port_pin_select_tb.sv
`timescale 1ns/1ps
`include "tdm_port_defines.svh"
`define CHK(nm, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         errors++; \
         $display("[ERR] %s exp %h got %h", nm, exp, got); \
      end \
   end
// Bench: registers over the bus, frames through the highway model
module tdm_serial_port_pin_select_tb
   import tdm_port_pkg::*;
;
   localparam int          LIMIT = 20000;
   localparam logic [12:0] BASE  = 13'h0003; // Highway on, sync high
   logic        clk, rst_n, go, busy, act_lvl;
   logic [4:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp, r;
   logic        bclk, fsync, rxa, rxb, da, da_oe_n, pb, pb_oe_n;
   logic [7:0]  rx_byte, cap_a, cap_b;
   int          errors, tests_run, cycles, n_a, n_b, na_clk, ns_clk;

   tdm_serial_port i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tx_bit_clock(bclk), .frame_sync_in(fsync), .rx_data_in_a(rxa),
      .rx_clk_or_data_b(rxb), .tx_data_out_a(da),
      .tx_data_out_a_oe_n(da_oe_n), .tx_b_strobe_pin(pb),
      .tx_b_strobe_pin_oe_n(pb_oe_n));

   tdm_highway_model i_hwy (.go(go), .rx_byte(rx_byte), .bit_clock(bclk),
      .frame_sync(fsync), .rx_a(rxa), .rx_b(rxb), .busy(busy));

   // 125 MHz master clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // At each active edge the previous bit is still standing: capture it
   always @(bclk)
      if (bclk === act_lvl)
      begin
         if (da_oe_n === 1'b0)
         begin
            cap_a = {da, cap_a[7:1]};
            n_a++;
         end
         if (pb_oe_n === 1'b0)
         begin
            cap_b = {pb, cap_b[7:1]};
            n_b++;
         end
      end

   // Cycles with A driven and with strobe low, compared afterwards
   always @(negedge clk)
   begin
      if (da_oe_n === 1'b0)
         na_clk++;
      if (pb === 1'b0)
         ns_clk++;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [7:0] rev8(input logic [7:0] v);
      return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction

   // Write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
      logic ta, tw, da_ok, dw_ok;
      da_ok = 1'b0;
      dw_ok = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(da_ok && dw_ok))
      begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge clk);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         da_ok = da_ok | ta;
         dw_ok = dw_ok | tw;
      end
      // Raised here so back-to-back writes never assign it twice at once
      bready <= 1'b1;
      do @(negedge clk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge clk);
      bready <= 1'b0;
   endtask

   // Read: hold the request until taken, then wait for the answer
   task automatic axi_rd(input logic [4:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(negedge clk); while (arready !== 1'b1);
      @(posedge clk);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge clk); while (rvalid !== 1'b1);
      r = rresp;
      @(posedge clk);
      rready <= 1'b0;
   endtask

   // Program control, clock one frame, let the outputs settle
   task automatic run_frame(input logic [12:0] c, input logic act);
      cap_a = 8'h00;
      cap_b = 8'h00;
      n_a = 0;
      n_b = 0;
      act_lvl = act;
      axi_wr(`OFS_CTRL, {19'h0, c});
      na_clk = 0;
      ns_clk = 0;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy)
         @(posedge clk);
      repeat (8) @(posedge clk);
   endtask

   task automatic t_reg_access();
      axi_rd(`OFS_CTRL);
      `CHK("ctrl reset", 32'h0, rdata)
      axi_wr(`OFS_TX_DATA, 32'h0000_00a5);
      axi_rd(`OFS_TX_DATA);
      `CHK("tx data", 32'h0000_00a5, rdata)
      `CHK("rd resp", `RESP_OKAY, r)
      axi_rd(5'h18);
      `CHK("unmapped rd", `RESP_SLVERR, r)
      axi_wr(5'h1c, 32'h0);
      `CHK("unmapped wr", `RESP_SLVERR, r)
   endtask

   task automatic t_tx_a_only();
      run_frame(BASE | 13'h0010, 1'b0);
      `CHK("a byte", 8'ha5, cap_a)
      `CHK("a bits", 8, n_a)
      `CHK("b idle", 0, n_b)
   endtask

   task automatic t_tx_both_inv_msb();
      run_frame(BASE | 13'h0370, 1'b1);
      `CHK("a rise inv msb", rev8(~8'ha5), cap_a)
      `CHK("b same", cap_a, cap_b)
      `CHK("b bits", 8, n_b)
   endtask

   task automatic t_strobe();
      // Output A enabled together with the strobe, as an external driver needs
      run_frame(BASE | 13'h0034, 1'b0);
      `CHK("a bits", 8, n_a)
      `CHK("strobe span", na_clk, ns_clk)
      `CHK("strobe used", 1'b1, na_clk > 0)
      `CHK("strobe idle", 1'b1, pb)
      // Strobe with only B enabled: no valid A bits, strobe stays high
      run_frame(BASE | 13'h0024, 1'b0);
      `CHK("strobe b only", 0, ns_clk)
      `CHK("strobe driven", 1'b0, pb_oe_n)
   endtask

   task automatic t_hwy_off();
      run_frame(13'h0012, 1'b0);
      `CHK("sync ignored", 0, n_a)
   endtask

   // Receive from input A and from the shared pin as data B, clocked by the transmit clock
   task automatic t_rx_paths();
      logic [12:0] cfg [4] = '{13'h0008, 13'h1008, 13'h0408, 13'h0808};
      logic [7:0]  exp [4];
      rx_byte = 8'h1d;
      exp = '{8'h1d, ~8'h1d, ~8'h1d, rev8(8'h1d)};
      for (int i = 0; i < 4; i++)
      begin
         run_frame(BASE | cfg[i], 1'b0);
         axi_rd(`OFS_RX_DATA);
         `CHK("rx byte", {24'h0, exp[i]}, rdata)
      end
   endtask

   initial
   begin
      rst_n = 1'b0;
      go = 1'b0;
      act_lvl = 1'b0;
      awaddr = 5'h00;
      araddr = 5'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      rx_byte = 8'h00;
      errors = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reg_access();
      t_tx_a_only();
      t_tx_both_inv_msb();
      t_strobe();
      t_hwy_off();
      t_rx_paths();
      tally_and_finish();
   end
endmodule
